// *** motion_pkg.sv ***
// Purpose: Constants and types shared by the motion / free-fall detector
// Assumes: 100 MHz sys_clk, 8-bit register port from the serial front end
// Notes:   Register addresses are the serial-port write addresses
// Summary of operation
// [R1] Rate select 00/01/10/11 samples at 250 Hz, 1 kHz, 4 kHz, 16 kHz.
// [R2] Motion non-latching: output follows the motion criterion.
// [R3] Motion latching: output holds high until motion enable input goes low.
// [R4] Free-fall non-latching: output follows the free-fall criterion.
// [R5] Free-fall latching: output holds until software clears then sets enable.
// [R6] Free-fall needs all three axes below the free-fall threshold.
// [R7] Free-fall threshold is 8 bits, one count per 16 axis counts.
// [R8] Free-fall condition must last the free-fall delay count of samples.
// [R9] Motion needs any one axis above the motion threshold.
// [R10] Motion threshold is 8 bits, one count per 16 axis counts.
// [R11] Motion condition must last the motion delay count of samples.
// [R12] Free-fall threshold register at 0x08, resets to 0x0E.
// [R13] Motion threshold register read/write, resets to 0x55.
// [R14] Motion delay register read/write, resets to one sample.
// [R15] Motion threshold at 0x0A; SPI reads use 0x8A with top bit set.
// [R16] Motion delay at 0x0B; SPI reads use 0x8B.
// [R17] Free-fall interrupt never asserts while its enable bit is clear.
// [R18] Free-fall status bit reads the free-fall output level.
// [R19] Debounce counters restart on any non-qualifying sample.
// [R20] Comparisons use the upper eight bits of each 12-bit sample.
package motion_pkg;
  localparam logic [6:0] ADDR_FF_THRESH  = 7'h08;
  localparam logic [6:0] ADDR_FREEFALL_DEBOUNCE_COUNT   = 7'h09;
  localparam logic [6:0] ADDR_MOT_THRESH = 7'h0A;
  localparam logic [6:0] ADDR_MOTION_DEBOUNCE_COUNT  = 7'h0B;
  localparam logic [6:0] ADDR_CONTROL_C  = 7'h0C;
  localparam logic [6:0] ADDR_CONTROL_B  = 7'h0D;
  localparam logic [6:0] ADDR_STATUS     = 7'h0E;
  localparam logic [7:0] RST_FF_THRESH   = 8'h0E;
  localparam logic [7:0] RST_FREEFALL_DEBOUNCE_COUNT    = 8'h00;
  localparam logic [7:0] RST_MOT_THRESH  = 8'h55;
  localparam logic [7:0] RST_MOTION_DEBOUNCE_COUNT   = 8'h01;
  localparam logic [7:0] RST_CONTROL_C   = 8'h00;
  localparam logic [7:0] RST_CONTROL_B   = 8'h42;
  localparam int BIT_FF_IEN   = 1;
  localparam int BIT_MOT_LAT  = 3;
  localparam int BIT_FF_LAT   = 4;
  localparam int BIT_STAT_MOT = 0;
  localparam int BIT_STAT_FF  = 1;
  localparam int CLK_HZ       = 100_000_000;
  localparam int RATE_250_HZ  = 250;
  localparam int RATE_1K_HZ   = 1_000;
  localparam int RATE_4K_HZ   = 4_000;
  localparam int RATE_16K_HZ  = 16_000;
  localparam int DIV_16K      = CLK_HZ / RATE_16K_HZ;
  localparam int DIV_4K       = CLK_HZ / RATE_4K_HZ;
  localparam int DIV_1K       = CLK_HZ / RATE_1K_HZ;
  localparam int DIV_250      = CLK_HZ / RATE_250_HZ;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } axes_type;
endpackage

// *** debounce_ctr.sv ***
// Purpose: Consecutive-sample debounce of one detection condition
// Assumes: sample_en is a one-cycle pulse at the debounce rate
// Notes:   A zero delay qualifies on the first matching sample
`timescale 1ns/100ps
`default_nettype none
module debounce_ctr (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Sample stream
  input  wire logic       sample_en,
  input  wire logic       cond,
  input  wire logic [7:0] delay,
  // Result
  output logic            met
);
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       met_d;
  wire        at_limit = (count_q >= delay);
  assign count_d = !cond ? 8'h00 : (at_limit ? count_q : count_q + 8'h01);
  // Nine-bit sum so a saturated count of 255 cannot wrap and drop met
  assign met_d   = cond && (at_limit || ({1'b0, count_q} + 9'h001 >= {1'b0, delay}));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
      met     <= 1'b0;
    end else if (sample_en) begin
      // [R19] Restart on miss
      count_q <= count_d;
      met     <= met_d;
    end
  end
  restart_a: assert property ( // [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    sample_en && !cond |=> count_q == 8'h00 && !met
  ) else $error("counter did not restart");
endmodule
`default_nettype wire

// *** accel_motion_freefall_detect.sv ***
// Purpose: Motion and free-fall interrupt logic with its register file
// Assumes: Serial front end delivers decoded byte reads and writes
// Notes:   Axis samples are taken as valid on every debounce tick
`timescale 1ns/100ps
`default_nettype none
module accel_motion_freefall_detect (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Register port
  input  wire motion_pkg::reg_req_type  req,
  output logic [7:0]                    rdata,
  // Sensor data and pins
  input  wire motion_pkg::axes_type     axes,
  input  wire logic                     motion_enable_input,
  output logic                          freefall_irq,
  output logic                          motion_irq
);
  logic [7:0]  freefall_threshold_q;
  logic [7:0]  freefall_debounce_count_q;
  logic [7:0]  motion_threshold_q;
  logic [7:0]  motion_debounce_count_q;
  logic [7:0]  control_b_q;
  logic [7:0]  control_c_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic [18:0] div_q;
  logic [18:0] div_limit;
  logic        tick;
  logic        ff_lat_q;
  logic        mot_lat_q;
  logic        ff_met;
  logic        mot_met;

  // [R15] Address decode, top bit marks SPI read
  wire [6:0] addr7        = req.addr[6:0];
  wire       wr_ff_thr    = req.wr && addr7 == motion_pkg::ADDR_FF_THRESH;
  wire       wr_ff_dly    = req.wr && addr7 == motion_pkg::ADDR_FREEFALL_DEBOUNCE_COUNT;
  wire       wr_mot_thr   = req.wr && addr7 == motion_pkg::ADDR_MOT_THRESH;
  wire       wr_mot_dly   = req.wr && addr7 == motion_pkg::ADDR_MOTION_DEBOUNCE_COUNT;
  wire       wr_ctl_c     = req.wr && addr7 == motion_pkg::ADDR_CONTROL_C;
  wire       wr_ctl_b     = req.wr && addr7 == motion_pkg::ADDR_CONTROL_B;
  wire       ff_ien       = control_b_q[motion_pkg::BIT_FF_IEN];
  wire       freefall_latch_sel = control_c_q[motion_pkg::BIT_FF_LAT];
  wire       motion_latch_sel   = control_c_q[motion_pkg::BIT_MOT_LAT];
  wire       debounce_rate_sel_hi = control_c_q[1];
  wire       debounce_rate_sel_lo = control_c_q[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // [R12] Free-fall threshold reset
      freefall_threshold_q      <= motion_pkg::RST_FF_THRESH;
      freefall_debounce_count_q <= motion_pkg::RST_FREEFALL_DEBOUNCE_COUNT;
      // [R13] Motion threshold reset
      motion_threshold_q        <= motion_pkg::RST_MOT_THRESH;
      // [R14] Motion delay reset
      motion_debounce_count_q   <= motion_pkg::RST_MOTION_DEBOUNCE_COUNT;
      control_b_q               <= motion_pkg::RST_CONTROL_B;
      control_c_q               <= motion_pkg::RST_CONTROL_C;
    end else begin
      if (wr_ff_thr) freefall_threshold_q <= req.wdata;
      if (wr_ff_dly) freefall_debounce_count_q <= req.wdata;
      // [R15] Motion threshold write
      if (wr_mot_thr) motion_threshold_q <= req.wdata;
      // [R16] Motion delay write
      if (wr_mot_dly) motion_debounce_count_q <= req.wdata;
      if (wr_ctl_b) control_b_q <= req.wdata;
      if (wr_ctl_c) control_c_q <= req.wdata;
    end
  end

  // [R18] Status mirrors outputs
  wire [7:0] status_val = {6'h00, freefall_irq, motion_irq};
  always_comb begin
    unique case (addr7)
      motion_pkg::ADDR_FF_THRESH:  rdata_d = freefall_threshold_q;
      motion_pkg::ADDR_FREEFALL_DEBOUNCE_COUNT:   rdata_d = freefall_debounce_count_q;
      motion_pkg::ADDR_MOT_THRESH: rdata_d = motion_threshold_q;
      motion_pkg::ADDR_MOTION_DEBOUNCE_COUNT:  rdata_d = motion_debounce_count_q;
      motion_pkg::ADDR_CONTROL_C:  rdata_d = control_c_q;
      motion_pkg::ADDR_CONTROL_B:  rdata_d = control_b_q;
      motion_pkg::ADDR_STATUS:     rdata_d = status_val;
      default:                     rdata_d = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 8'h00;
    else if (req.rd) rdata_q <= rdata_d;
  end
  assign rdata = rdata_q;

  // [R1] Debounce rate divider
  assign div_limit = debounce_rate_sel_hi ?
                     (debounce_rate_sel_lo ? 19'(motion_pkg::DIV_16K) : 19'(motion_pkg::DIV_4K)) :
                     (debounce_rate_sel_lo ? 19'(motion_pkg::DIV_1K)  : 19'(motion_pkg::DIV_250));
  // Greater-or-equal so a switch to a faster rate with the count already past its limit ticks at once, never wraps
  assign tick = (div_q >= div_limit - 19'h00001);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) div_q <= 19'h00000;
    else div_q <= tick ? 19'h00000 : div_q + 19'h00001;
  end

  // [R20] Upper eight bits, [R7] [R10] 16 counts per step
  wire [7:0] xs = axes.x[11:4];
  wire [7:0] ys = axes.y[11:4];
  wire [7:0] zs = axes.z[11:4];
  // [R6] All axes below
  wire ff_cond  = xs < freefall_threshold_q && ys < freefall_threshold_q && zs < freefall_threshold_q;
  // [R9] Any axis above
  wire mot_cond = xs > motion_threshold_q || ys > motion_threshold_q || zs > motion_threshold_q;

  // [R8] Free-fall debounce
  debounce_ctr u_ff_deb (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sample_en (tick),
    .cond      (ff_cond && ff_ien),
    .delay     (freefall_debounce_count_q),
    .met       (ff_met)
  );
  // [R11] Motion debounce
  debounce_ctr u_mot_deb (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sample_en (tick),
    .cond      (mot_cond && motion_enable_input),
    .delay     (motion_debounce_count_q),
    .met       (mot_met)
  );

  // Latches: clear wins over set, cleared only by the enable cycling low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_lat_q      <= 1'b0;
      mot_lat_q     <= 1'b0;
    end else begin
      // [R5] Held until enable cycles
      if (!ff_ien) ff_lat_q <= 1'b0;
      else if (ff_met && freefall_latch_sel) ff_lat_q <= 1'b1;
      // [R3] Held until enable pin low
      if (!motion_enable_input) mot_lat_q <= 1'b0;
      else if (mot_met && motion_latch_sel) mot_lat_q <= 1'b1;
    end
  end

  // [R4] [R17] Free-fall output
  assign freefall_irq = ff_ien && (freefall_latch_sel ? (ff_lat_q || ff_met) : ff_met);
  // [R2] Motion output
  assign motion_irq = motion_enable_input && (motion_latch_sel ? (mot_lat_q || mot_met) : mot_met);

  // Checks
  ff_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ff_ien |-> !freefall_irq) else $error("free-fall without enable"); // [R17]
  ff_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !freefall_latch_sel |-> freefall_irq == (ff_met && ff_ien)) else $error("free-fall not following"); // [R4]
  mot_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !motion_latch_sel && motion_enable_input |-> motion_irq == mot_met) else $error("motion not following"); // [R2]
  mot_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    motion_latch_sel && motion_irq ##1 motion_latch_sel && motion_enable_input |-> motion_irq)
    else $error("motion latch dropped"); // [R3]
  ff_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    freefall_latch_sel && freefall_irq ##1 freefall_latch_sel && ff_ien |-> freefall_irq)
    else $error("free-fall latch dropped"); // [R5]
  status_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && addr7 == motion_pkg::ADDR_STATUS |=> rdata[1] == $past(freefall_irq))
    else $error("status mismatch"); // [R18]
  rate_fast_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && control_c_q[1:0] == 2'b11 ##1 !wr_ctl_c [*8] |-> !tick) else $error("tick too early"); // [R1]
  mot_thr_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_mot_thr |=> motion_threshold_q == $past(req.wdata)) else $error("threshold write lost"); // [R15]

  // Tick spacing reference, cleared by a control C write outside a tick cycle until the next tick
  logic [18:0] gap_q;
  logic        gap_ok_q;
  wire  [18:0] period_exp = (control_c_q[1:0] == 2'b11) ? 19'(motion_pkg::DIV_16K) :
                            (control_c_q[1:0] == 2'b10) ? 19'(motion_pkg::DIV_4K)  :
                            (control_c_q[1:0] == 2'b01) ? 19'(motion_pkg::DIV_1K)  :
                                                          19'(motion_pkg::DIV_250);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q    <= 19'h00000;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q <= tick ? 19'h00000 : gap_q + 19'h00001;
      if (tick) gap_ok_q <= 1'b1;
      else if (wr_ctl_c) gap_ok_q <= 1'b0;
    end
  end

  // Sample steps used by the detection checks
  sequence ff_sample_s;
    tick && ff_cond && ff_ien;
  endsequence

  sequence mot_sample_s;
    tick && mot_cond && motion_enable_input;
  endsequence

  sequence ff_first_s;
    tick && ff_cond && ff_ien && freefall_debounce_count_q <= 8'h01;
  endsequence

  sequence mot_first_s;
    tick && mot_cond && motion_enable_input && motion_debounce_count_q <= 8'h01;
  endsequence

  sequence ff_miss_s;
    tick && !(ff_cond && ff_ien);
  endsequence

  sequence mot_miss_s;
    tick && !(mot_cond && motion_enable_input);
  endsequence

  sequence status_rd_s;
    req.rd && addr7 == motion_pkg::ADDR_STATUS;
  endsequence

  sequence mot_set_s;
    motion_latch_sel && mot_met && motion_enable_input;
  endsequence

  rate_period_a: assert property ( // [R1]
    @(posedge sys_clk) disable iff (!rst_n)
    tick && gap_ok_q && !wr_ctl_c |-> gap_q == period_exp - 19'h00001
  ) else $error("tick period wrong");

  ff_thr_wr_a: assert property ( // [R12]
    @(posedge sys_clk) disable iff (!rst_n)
    wr_ff_thr |=> freefall_threshold_q == $past(req.wdata)
  ) else $error("free-fall threshold write lost");

  mot_dly_wr_a: assert property ( // [R16]
    @(posedge sys_clk) disable iff (!rst_n)
    wr_mot_dly |=> motion_debounce_count_q == $past(req.wdata)
  ) else $error("motion delay write lost");

  mot_gate_a: assert property ( // [R3]
    @(posedge sys_clk) disable iff (!rst_n)
    !motion_enable_input |-> !motion_irq
  ) else $error("motion without enable pin");

  mot_clear_a: assert property ( // [R3]
    @(posedge sys_clk) disable iff (!rst_n)
    !motion_enable_input |=> !mot_lat_q
  ) else $error("motion latch not cleared");

  mot_lat_set_a: assert property ( // [R3]
    @(posedge sys_clk) disable iff (!rst_n)
    mot_set_s |=> mot_lat_q || !motion_enable_input
  ) else $error("motion latch not set");

  ff_clear_a: assert property ( // [R5]
    @(posedge sys_clk) disable iff (!rst_n)
    !ff_ien |=> !ff_lat_q
  ) else $error("free-fall latch not cleared");

  ff_first_a: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!rst_n)
    ff_first_s |=> ff_met
  ) else $error("free-fall not met on first sample");

  mot_first_a: assert property ( // [R11]
    @(posedge sys_clk) disable iff (!rst_n)
    mot_first_s |=> mot_met
  ) else $error("motion not met on first sample");

  ff_miss_a: assert property ( // [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    ff_miss_s |=> !ff_met
  ) else $error("free-fall debounce not restarted");

  mot_miss_a: assert property ( // [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    mot_miss_s |=> !mot_met
  ) else $error("motion debounce not restarted");

  ff_steady_a: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!rst_n)
    !tick |=> $stable(ff_met)
  ) else $error("free-fall result moved between samples");

  mot_steady_a: assert property ( // [R11]
    @(posedge sys_clk) disable iff (!rst_n)
    !tick |=> $stable(mot_met)
  ) else $error("motion result moved between samples");

  ff_one_above_a: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!rst_n)
    tick && (xs >= freefall_threshold_q || ys >= freefall_threshold_q) |=> !ff_met
  ) else $error("free-fall met with an axis above");

  mot_none_above_a: assert property ( // [R9]
    @(posedge sys_clk) disable iff (!rst_n)
    tick && xs <= motion_threshold_q && ys <= motion_threshold_q && zs <= motion_threshold_q |=> !mot_met
  ) else $error("motion met with no axis above");

  ff_sample_a: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!rst_n)
    ff_sample_s ##1 !tick |-> ff_met || freefall_debounce_count_q > 8'h01 || $past(freefall_debounce_count_q) > 8'h01
  ) else $error("free-fall sample lost");

  mot_sample_a: assert property ( // [R9]
    @(posedge sys_clk) disable iff (!rst_n)
    mot_sample_s ##1 !tick |-> mot_met || motion_debounce_count_q > 8'h01 || $past(motion_debounce_count_q) > 8'h01
  ) else $error("motion sample lost");

  mot_status_a: assert property ( // [R18]
    @(posedge sys_clk) disable iff (!rst_n)
    status_rd_s |=> rdata[0] == $past(motion_irq)
  ) else $error("motion status mismatch");

  rd_mot_thr_a: assert property ( // [R15]
    @(posedge sys_clk) disable iff (!rst_n)
    req.rd && addr7 == motion_pkg::ADDR_MOT_THRESH |=> rdata == $past(motion_threshold_q)
  ) else $error("motion threshold read wrong");

  rd_mot_dly_a: assert property ( // [R16]
    @(posedge sys_clk) disable iff (!rst_n)
    req.rd && addr7 == motion_pkg::ADDR_MOTION_DEBOUNCE_COUNT |=> rdata == $past(motion_debounce_count_q)
  ) else $error("motion delay read wrong");

  rd_ff_thr_a: assert property ( // [R12]
    @(posedge sys_clk) disable iff (!rst_n)
    req.rd && addr7 == motion_pkg::ADDR_FF_THRESH |=> rdata == $past(freefall_threshold_q)
  ) else $error("free-fall threshold read wrong");

  rd_unmapped_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req.rd && (addr7 > motion_pkg::ADDR_STATUS || addr7 < motion_pkg::ADDR_FF_THRESH) |=> rdata == 8'h00
  ) else $error("unmapped read not zero");

  rd_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !req.rd |=> $stable(rdata)
  ) else $error("read data moved without a read");
endmodule
`default_nettype wire

// *** host_model.sv ***
// Purpose: Host-side model issuing byte reads and writes to the register port
// Assumes: One request at a time, changed 1 ns after sys_clk rises
// Notes:   Released address shows inverted value, data inverted after writes and 0xFF after reads, so stale bytes never match
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic                    sys_clk,
  // Register port
  input  wire logic [7:0]              rdata,
  output var  motion_pkg::reg_req_type req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a | 8'h80, wdata: 8'h00};
    @(posedge sys_clk) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge sys_clk) #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// *** accel_motion_freefall_detect_tb.sv ***
// Purpose: Self-checking bench for the motion and free-fall detector
// Assumes: 16 kHz debounce rate keeps the run short
// Notes:   Tick phase is unknown, so waits allow one extra tick
`timescale 1ns/100ps
`default_nettype none
module accel_motion_freefall_detect_tb;
  localparam int T = motion_pkg::DIV_16K;
  localparam motion_pkg::axes_type QUIET = '{12'h300, 12'h300, 12'h300};
  logic                    sys_clk;
  logic                    rst_n;
  motion_pkg::reg_req_type req;
  logic [7:0]              rdata;
  motion_pkg::axes_type    axes;
  logic                    motion_enable_input;
  logic                    freefall_irq;
  logic                    motion_irq;
  logic [7:0]              d;
  logic [7:0]              v;
  logic [7:0]              tbl [3] = '{8'h08, 8'h0A, 8'h0B};
  int                      seed;
  int                      miscompares = 0;
  int                      comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  host_model hm (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  accel_motion_freefall_detect uut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .axes(axes),
    .motion_enable_input(motion_enable_input), .freefall_irq(freefall_irq), .motion_irq(motion_irq));
  function automatic logic mot_cond(input motion_pkg::axes_type a, input logic [7:0] thr);
    return a.x[11:4] > thr || a.y[11:4] > thr || a.z[11:4] > thr;
  endfunction
  function automatic logic ff_cond(input motion_pkg::axes_type a, input logic [7:0] thr);
    return a.x[11:4] < thr && a.y[11:4] < thr && a.z[11:4] < thr;
  endfunction
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait; a miss is counted and ends the run
  task automatic wait_for(input logic sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel ? freefall_irq : motion_irq) !== lvl && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({7'h00, sel ? freefall_irq : motion_irq}, {7'h00, lvl});
    if ((sel ? freefall_irq : motion_irq) !== lvl) close_out();
  endtask
  initial begin
    seed = 55;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    axes = QUIET;
    motion_enable_input = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    hm.rd(8'h88, d);
    chk(d, 8'h0E);
    hm.rd(8'h8A, d);
    chk(d, 8'h55);
    hm.rd(8'h8B, d);
    chk(d, 8'h01);
    hm.rd(8'h8F, d);
    chk(d, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      hm.wr(tbl[i], v);
      hm.rd(tbl[i], d);
      chk(d, v);
    end
    $display("test registers done");
    hm.wr(8'h0C, 8'h03);
    hm.wr(8'h08, 8'h0E);
    hm.wr(8'h0A, 8'h40);
    hm.wr(8'h0B, 8'h02);
    axes.y = 12'h410 + 12'($random(seed) & 32'h3FF);
    wait_for(1'b0, mot_cond(axes, 8'h40), 3 * T + 20);
    axes = QUIET;
    wait_for(1'b0, mot_cond(axes, 8'h40), T + 20);
    hm.wr(8'h0C, 8'h0B);
    axes.z = 12'hFF0;
    wait_for(1'b0, 1'b1, 3 * T + 20);
    axes = QUIET;
    repeat (T + 20) @(posedge sys_clk);
    chk({7'h00, motion_irq}, 8'h01);
    motion_enable_input = 1'b0;
    wait_for(1'b0, 1'b0, 20);
    motion_enable_input = 1'b1;
    $display("test motion done");
    hm.wr(8'h0C, 8'h13);
    axes = '{12'($random(seed)) & 12'h0DF, 12'h0A0, 12'h0DF};
    wait_for(1'b1, ff_cond(axes, 8'h0E), T + 20);
    hm.rd(8'h8E, d);
    chk(d & 8'h02, 8'h02);
    axes = QUIET;
    repeat (T + 20) @(posedge sys_clk);
    chk({7'h00, freefall_irq}, 8'h01);
    axes = '{12'h0A0, 12'h0A0, 12'h0A0};
    hm.wr(8'h0D, 8'h40);
    wait_for(1'b1, 1'b0, 20);
    repeat (T + 20) @(posedge sys_clk);
    chk({7'h00, freefall_irq}, 8'h00);
    hm.wr(8'h0D, 8'h42);
    wait_for(1'b1, 1'b1, T + 20);
    hm.wr(8'h0C, 8'h03);
    axes.x = 12'h300;
    wait_for(1'b1, ff_cond(axes, 8'h0E), T + 20);
    hm.rd(8'h8E, d);
    chk(d & 8'h02, 8'h00);
    $display("test freefall done");
    close_out();
  end
endmodule
`default_nettype wire
